// >>> inc/swap_cap_pkg.sv
// package for the configuration swap control and capability header registers
// assumes a byte-addressed configuration access port with byte enables
package swap_cap_pkg;
    localparam logic [7:0]  swap_ctrl_off    = 8'h40;
    localparam logic [7:0]  cap_hdr_off      = 8'h44;
    localparam logic [31:0] swap_ctrl_rst    = 32'h0000_0000;
    localparam int          swap_bit_pos     = 0;
    localparam logic [7:0]  cap_list_code    = 8'h01;
    localparam logic [7:0]  cap_next_ptr     = 8'h00;
    localparam logic [15:0] cap_hdr_val      = {cap_next_ptr, cap_list_code};
    localparam logic [31:0] rd_zero          = 32'h0000_0000;

    // one configuration access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    // one quadlet on the bus side of the swap path
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } quad_t;
endpackage : swap_cap_pkg

// >>> hdl/swap_cap_regs.sv
// configuration swap control register, capability header and quadlet swap path
// assumes single-cycle config requests on mclk; read data appears one cycle later
//
// Overview of operation
// - swap bit set reverses every quadlet's bytes
// - swap bit resets to zero, little endian
// - bits 31..1 read zero, writes ignored
// - control register at 40h, resets all zero
// - capability header at 44h, read-only 0001h
// - next pointer bits 15..8 read 00h
// - capability code bits 7..0 read 01h
module swap_cap_regs
    import swap_cap_pkg::*;
(
    input  wire logic        mclk,       // bus clock
    input  wire logic        rst_b,      // async reset, active low
    input  wire cfg_req_t    cfg_req,    // configuration access
    output logic [31:0]      cfg_rdata,  // read data, one cycle after rd
    output logic             cfg_rvalid, // read data valid pulse
    input  wire quad_t       quad_in,    // quadlet crossing the bus interface
    output quad_t            quad_out,   // quadlet after optional swap
    output logic             swap_en     // current swap control bit
);
    logic        swap_q;     // stored swap control bit
    logic [31:0] rdata_q;    // registered read data
    logic        rvalid_q;   // read strobe delayed one cycle
    quad_t       quad_q;     // swap path output stage
    logic        ctrl_wr;    // write that reaches the swap bit
    logic        ctrl_rd;    // read of the control register
    logic        hdr_rd;     // read of the capability header

    function automatic logic [31:0] byte_rev(input logic [31:0] v);
        byte_rev = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : byte_rev

    // address match shared by the write path and the read mux
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    // read-back image of the control register: only bit 0 is live
    function automatic logic [31:0] ctrl_image(input logic s);
        ctrl_image = {31'h0000_0000, s};
    endfunction : ctrl_image

    assign ctrl_wr = cfg_req.wr && addr_is(cfg_req.addr, swap_ctrl_off) && cfg_req.be[0];
    assign ctrl_rd = cfg_req.rd && addr_is(cfg_req.addr, swap_ctrl_off);
    assign hdr_rd  = cfg_req.rd && addr_is(cfg_req.addr, cap_hdr_off);

    // only bit 0 holds state; upper bits have no storage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            swap_q <= swap_ctrl_rst[swap_bit_pos];
        end else if (ctrl_wr) begin
            swap_q <= cfg_req.wdata[swap_bit_pos];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cfg_req.rd;
        end
    end

    // read data holds until the next read; a read beside a write sees the old bit
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= rd_zero;
        end else if (cfg_req.rd) begin
            if (ctrl_rd) begin
                rdata_q <= ctrl_image(swap_q);
            end else if (hdr_rd) begin
                rdata_q <= {16'h0000, cap_hdr_val};
            end else begin
                rdata_q <= rd_zero;
            end
        end
    end

    // one register stage; valid and data move together
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            quad_q <= '0;
        end else begin
            quad_q.valid <= quad_in.valid;
            quad_q.data  <= swap_q ? byte_rev(quad_in.data) : quad_in.data;
        end
    end

    assign cfg_rdata  = rdata_q;
    assign cfg_rvalid = rvalid_q;
    assign quad_out   = quad_q;
    assign swap_en    = swap_q;

    // checks: swap path
    property p_swap_path;
        @(posedge mclk) disable iff (!rst_b)
        swap_q |=>
            quad_q.data == byte_rev($past(quad_in.data));
    endproperty
    a_swap_path: assert property (p_swap_path) else $error("quadlet not swapped");

    property p_pass_path;
        @(posedge mclk) disable iff (!rst_b)
        !swap_q |=>
            quad_q.data == $past(quad_in.data);
    endproperty
    a_pass_path: assert property (p_pass_path) else $error("quadlet altered");

    property p_q_valid;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 |=>
            quad_q.valid == $past(quad_in.valid);
    endproperty
    a_q_valid: assert property (p_q_valid) else $error("quadlet valid lost");

    // checks: control register and unmapped reads
    property p_ctrl_rsvd;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr == swap_ctrl_off |=>
            rdata_q[31:1] == 31'h0;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits nonzero");

    property p_ctrl_read;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr == swap_ctrl_off |=>
            rdata_q[0] == $past(swap_q);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

    property p_ctrl_write;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.wr && cfg_req.addr == swap_ctrl_off && cfg_req.be[0] |=>
            swap_q == $past(cfg_req.wdata[0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_swap_stable;
        @(posedge mclk) disable iff (!rst_b)
        !(cfg_req.wr && cfg_req.addr == swap_ctrl_off) |=>
            $stable(swap_q);
    endproperty
    a_swap_stable: assert property (p_swap_stable) else $error("swap bit changed");

    property p_be_mask;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.wr && cfg_req.addr == swap_ctrl_off && !cfg_req.be[0] |=>
            $stable(swap_q);
    endproperty
    a_be_mask: assert property (p_be_mask) else $error("masked write applied");

    property p_unmapped;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr != swap_ctrl_off && cfg_req.addr != cap_hdr_off |=>
            rdata_q == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

    // checks: capability header
    property p_cap_read;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr == cap_hdr_off |=>
            rvalid_q && rdata_q == 32'h0000_0001;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capability header wrong");

    property p_cap_next;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr == cap_hdr_off |=>
            rdata_q[15:8] == 8'h00;
    endproperty
    a_cap_next: assert property (p_cap_next) else $error("next pointer nonzero");

    property p_cap_code;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr == cap_hdr_off |=>
            rdata_q[7:0] == 8'h01;
    endproperty
    a_cap_code: assert property (p_cap_code) else $error("capability code wrong");

    // checks: read strobe and data
    property p_rv_set;
        @(posedge mclk) disable iff (!rst_b)
        cfg_req.rd |=>
            rvalid_q;
    endproperty
    a_rv_set: assert property (p_rv_set) else $error("read valid missing");

    property p_rv_clr;
        @(posedge mclk) disable iff (!rst_b)
        !cfg_req.rd |=>
            !rvalid_q;
    endproperty
    a_rv_clr: assert property (p_rv_clr) else $error("read valid without read");

    property p_rd_hold;
        @(posedge mclk) disable iff (!rst_b)
        !cfg_req.rd |=>
            $stable(rdata_q);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed");

    // checks: values held in reset
    property p_rst_swap;
        @(posedge mclk)
        !rst_b ##1 !rst_b |->
            swap_q == 1'b0;
    endproperty
    a_rst_swap: assert property (p_rst_swap) else $error("swap bit not cleared");

    property p_rst_regs;
        @(posedge mclk)
        !rst_b ##1 !rst_b |->
            rdata_q == 32'h0000_0000 && !rvalid_q && quad_q == '0;
    endproperty
    a_rst_regs: assert property (p_rst_regs) else $error("outputs not cleared");

    // scenarios reached
    c_swap_set:  cover property (@(posedge mclk) disable iff (!rst_b) $rose(swap_q));
    c_swap_clr:  cover property (@(posedge mclk) disable iff (!rst_b) $fell(swap_q));
    c_cap_read:  cover property (@(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && cfg_req.addr == cap_hdr_off);
    c_swap_data: cover property (@(posedge mclk) disable iff (!rst_b) swap_q && quad_in.valid);
    c_unmapped:  cover property (@(posedge mclk) disable iff (!rst_b)
        cfg_req.rd && !ctrl_rd && !hdr_rd);
endmodule : swap_cap_regs

// >>> verification/tb_swap_cap_regs.sv
// testbench for swap_cap_regs: reset values, register access, quadlet swap
// assumes swap_cap_pkg compiled first; inputs change at the falling edge
module tb_swap_cap_regs
    import swap_cap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 0;
    logic        rst_b = 0;
    logic        swap_en;
    logic        cfg_rvalid;
    logic [31:0] cfg_rdata;
    cfg_req_t    cfg_req = '0;
    quad_t       quad_in = '0;
    quad_t       quad_out;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #2.5 mclk = ~mclk;
    swap_cap_regs swap_cap_regs_i (.mclk(mclk), .rst_b(rst_b), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .quad_in(quad_in),
        .quad_out(quad_out), .swap_en(swap_en));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] wd, input logic [31:0] exp);
        @(negedge mclk);
        chk({31'h0, cfg_rvalid}, 32'h0);
        cfg_req = '{r, w, a, be, wd};
        @(negedge mclk) cfg_req = '0;
        chk({31'h0, cfg_rvalid}, {31'h0, r});
        if (r) begin
            chk(cfg_rdata, exp);
        end
    endtask : acc
    task automatic quad(input logic [31:0] d, input logic [31:0] exp);
        @(negedge mclk) quad_in = '{1'b1, d};
        @(negedge mclk) quad_in = '0;
        chk({31'h0, quad_out.valid}, 32'h1);
        chk(quad_out.data, exp);
    endtask : quad
    task automatic t_reset();
        chk({31'h0, swap_en}, 32'h0);
        acc(1'b1, 1'b0, swap_ctrl_off, 4'hf, 32'h0, 32'h0);
        acc(1'b1, 1'b0, cap_hdr_off, 4'hf, 32'h0, 32'h1);
        quad(32'h1234_5678, 32'h1234_5678);
        $display("test reset done");
    endtask : t_reset
    task automatic t_write();
        acc(1'b0, 1'b1, swap_ctrl_off, 4'hf, 32'hffff_ffff, 32'h0);
        chk({31'h0, swap_en}, 32'h1);
        acc(1'b1, 1'b0, swap_ctrl_off, 4'hf, 32'h0, 32'h1);
        quad(32'h1234_5678, 32'h7856_3412);
        acc(1'b0, 1'b1, cap_hdr_off, 4'hf, 32'hffff_fffe, 32'h0);
        acc(1'b1, 1'b0, cap_hdr_off, 4'hf, 32'h0, 32'h1);
        acc(1'b1, 1'b0, 8'h80, 4'hf, 32'h0, 32'h0);
        acc(1'b0, 1'b1, swap_ctrl_off, 4'hf, 32'hffff_fffe, 32'h0);
        chk({31'h0, swap_en}, 32'h0);
        quad(32'ha1b2_c3d4, 32'ha1b2_c3d4);
        $display("test write done");
    endtask : t_write
    task automatic t_byte_en();
        acc(1'b0, 1'b1, swap_ctrl_off, 4'he, 32'h1, 32'h0);
        chk({31'h0, swap_en}, 32'h0);
        acc(1'b0, 1'b1, swap_ctrl_off, 4'h1, 32'h1, 32'h0);
        chk({31'h0, swap_en}, 32'h1);
        acc(1'b1, 1'b1, swap_ctrl_off, 4'hf, 32'h0, 32'h1);
        chk({31'h0, swap_en}, 32'h0);
        $display("test byte enable done");
    endtask : t_byte_en
    task automatic t_mid_reset();
        acc(1'b0, 1'b1, swap_ctrl_off, 4'hf, 32'h1, 32'h0);
        chk({31'h0, swap_en}, 32'h1);
        @(negedge mclk) rst_b = 1'b0;
        repeat (3) @(negedge mclk);
        chk({31'h0, swap_en}, 32'h0);
        chk(cfg_rdata, 32'h0);
        chk({30'h0, cfg_rvalid, quad_out.valid}, 32'h0);
        rst_b = 1'b1;
        chk({31'h0, swap_en}, 32'h0);
        acc(1'b1, 1'b0, swap_ctrl_off, 4'hf, 32'h0, 32'h0);
        quad(32'h0102_0304, 32'h0102_0304);
        $display("test mid reset done");
    endtask : t_mid_reset
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(negedge mclk);
        rst_b = 1;
        t_reset();
        t_write();
        t_byte_en();
        t_mid_reset();
        print_verdict();
    end
endmodule : tb_swap_cap_regs
